// *** design/fbs_regs.svh ***
`ifndef FBS_REGS_SVH
`define FBS_REGS_SVH
// Clock rate in kHz and timing figures in their own units
`define FBS_CLK_KHZ        200000
`define FBS_WDOG_MS        40
`define FBS_WDOG_CYC       (`FBS_WDOG_MS * `FBS_CLK_KHZ)
`define FBS_SEND_NS        6000
`define FBS_SEND_CYC       ((`FBS_SEND_NS * (`FBS_CLK_KHZ / 1000)) / 1000)
`define FBS_STRB_RST_NS    44000
`define FBS_STRB_RST_CYC   (((`FBS_STRB_RST_NS * (`FBS_CLK_KHZ / 1000)) + 999) / 1000)
`define FBS_LED_HALF_MS    250
`define FBS_LED_HALF_CYC   (`FBS_LED_HALF_MS * `FBS_CLK_KHZ)
`define FBS_MUX_NS         2500
`define FBS_MUX_CYC        ((`FBS_MUX_NS * (`FBS_CLK_KHZ / 1000)) / 1000)
// Request field positions in the 11-bit body {cb, a4..a0, i4..i0}
`define FBS_CB_POS         10
`define FBS_ADDR_MSB       9
`define FBS_ADDR_LSB       5
`define FBS_INFO_MSB       4
`define FBS_INFO_LSB       0
`define FBS_SEL_POS        3
// Reset values
`define FBS_STATUS_RST     4'h0
`define FBS_PARAM_RST      4'hF
`define FBS_DATA_RST       4'h0
// Fixed reply codes and request codes
`define FBS_ACK_REPLY      4'h6
`define FBS_ZERO_REPLY     4'h0
`define FBS_ENTER_PROGRAM_MODE_REQUEST_INFO      5'h1D
`define FBS_BCAST_INFO     5'h15
`define FBS_BCAST_ADDR     5'h1F
`endif

// *** design/fbs_pkg.sv ***
package fbs_pkg;
   // Main control state machine
   typedef enum logic [2:0]
   {
      FBS_IDLE  = 3'b000,
      FBS_EXEC  = 3'b001,
      FBS_REPLY = 3'b010,
      FBS_SHUT  = 3'b011
   } fbs_state_e;
   typedef logic [3:0] fbs_nib_t;
endpackage

// *** design/fbs_sync.sv ***
module fbs_sync
   import fbs_pkg::*;
(
   input  wire logic core_clk_i,
   input  wire logic rst_n_i,
   input  wire logic d_i,
   output logic      q_o
);
   logic meta;
   // Two-stage synchroniser; first stage feeds only the second
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         meta <= 1'b0;
         q_o  <= 1'b0;
      end
      else
      begin
         meta <= d_i;
         q_o  <= meta;
      end
   end
endmodule

// *** design/fbs_timer.sv ***
module fbs_timer
   import fbs_pkg::*;
#(
   parameter int W = 24
)
(
   input  wire logic         core_clk_i,
   input  wire logic         rst_n_i,
   input  wire logic         run_i,
   input  wire logic         clr_i,
   input  wire logic [W-1:0] limit_i,
   output logic              hit_o
);
   logic [W-1:0] cnt;
   // Counts while run, restart on clear; hit is a one-cycle pulse
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cnt   <= '0;
         hit_o <= 1'b0;
      end
      else if (clr_i || !run_i)
      begin
         cnt   <= '0;
         hit_o <= 1'b0;
      end
      else if (cnt == limit_i - W'(1))
      begin
         cnt   <= '0;
         hit_o <= 1'b1;
      end
      else
      begin
         cnt   <= cnt + W'(1);
         hit_o <= 1'b0;
      end
   end
endmodule

// *** design/fbs_ctrl.sv ***
`include "fbs_regs.svh"
// Functional notes
// - Data out and in always separate ports
// - Multiplex flag floats outputs after strobe
// - Invert flag inverts data inputs
// - Parameter port open-drain, read wired-AND
// - Watchdog works only when enabled
// - Parameter write arms watchdog, nonzero address
// - Reset or delete address disarms watchdog
// - 40ms silence: reset, outputs inactive
// - Fault high: status bit set, LED flashes
// - Fault low: clear bit, LED from inhibit
// - Reset sets inhibit; parameter write clears
// - Inhibit blocks data exchange, LED on
// - Fault flashing overrides inhibit steady LED
// - Optical channel lock: LED carries reply
// - Overtemperature shuts down until power-on
// - Illegal state forces slave reset
// - Request and reply frame formats
// - Extended ID write stored, zero reply
// - Extended mode checks A/B select bit
// - Program mode only if not disabled
// - Send strobe within 6us of request
// - Strobe pin low over 44us resets
// - Status bit 1 via synchroniser
module fbs_ctrl
   import fbs_pkg::*;
#(
   parameter int WDOG_CYC = `FBS_WDOG_CYC,
   parameter int LED_CYC  = `FBS_LED_HALF_CYC
)
(
   input  wire logic        core_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        receive_valid_strobe_i,
   input  wire logic [10:0] req_body_i,
   output logic             transmit_request_strobe_o,
   output logic [3:0]       reply_info_o,
   output logic             reply_parity_bit_o,
   input  wire logic [4:0]  slave_addr_i,
   input  wire logic        ext_addr_mode_i,
   input  wire logic        own_select_i,
   input  wire logic [3:0]  io_config_i,
   input  wire logic [3:0]  id_code_i,
   input  wire logic [3:0]  id_code_two_i,
   input  wire logic        nv_mux_i,
   input  wire logic        nv_invert_i,
   input  wire logic        nv_wdog_en_i,
   input  wire logic        nv_prog_dis_i,
   input  wire logic [3:0]  data_in_i,
   output logic [3:0]       data_out_o,
   output logic             data_out_oe_o,
   output logic             data_strobe_o,
   output logic             data_strobe_oe_o,
   input  wire logic        data_strobe_i,
   input  wire logic [3:0]  param_i,
   output logic [3:0]       param_o,
   output logic             parameter_strobe_output_o,
   input  wire logic        fault_input_i,
   output logic             status_bit_one_o,
   input  wire logic        optical_lock_i,
   input  wire logic        optical_reply_i,
   output logic             led_on_o,
   input  wire logic        overtemp_i,
   output logic             shutdown_o,
   output logic             prog_mode_o,
   output logic             wdog_armed_o,
   output logic             inhibit_o,
   output logic [3:0]       ext_id_o
);
   //--------------------------------------------------------------
   // Decode
   //--------------------------------------------------------------
   fbs_state_e  state;
   logic [10:0] req;
   logic        fault_s;
   logic        soft_rst;
   logic        wd_hit;
   logic        led_hit;
   logic        mux_hit;
   logic        strb_hit;
   logic        blink;
   logic        mux_run;
   logic        strb_low;
   logic [3:0]  reply;
   logic        do_reply;
   logic        is_write_parameter_request;
   logic        is_data_exchange_request;
   logic        is_delete_address_request;
   logic        is_res;
   logic        addr_hit;
   logic        sel_ok;
   logic        cb;
   logic [4:0]  ad;
   logic [4:0]  inf;
   logic [3:0] data_in_eff;

   default clocking cb_chk @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   assign cb  = req[`FBS_CB_POS];
   assign ad  = req[`FBS_ADDR_MSB:`FBS_ADDR_LSB];
   assign inf = req[`FBS_INFO_MSB:`FBS_INFO_LSB];
   // Select is true in some calls, inverted in others
   always_comb
   begin
      sel_ok = 1'b1;
      if (ext_addr_mode_i)
      begin
         if ((!cb && inf[4]) || (!cb && !inf[4])
             || (cb && inf[4] && inf[2]))
            sel_ok = (inf[`FBS_SEL_POS] == !own_select_i);
         else
            sel_ok = (inf[`FBS_SEL_POS] == own_select_i);
      end
   end
   assign addr_hit = (ad == slave_addr_i) && sel_ok;
   assign is_data_exchange_request  = addr_hit && !cb && !inf[4];
   assign is_write_parameter_request  = addr_hit && !cb && inf[4];
   assign is_delete_address_request  = addr_hit && cb && inf[4:0] == 5'h00
                     | (addr_hit && cb && !inf[4] && ext_addr_mode_i
                        && inf[2:0] == 3'h0);
   assign is_res   = addr_hit && cb && inf[4] && inf[2:0] == 3'h4;
   assign data_in_eff = nv_invert_i ? ~data_in_i : data_in_i;

   // Reply selection per request type
   always_comb
   begin
      reply    = `FBS_ZERO_REPLY;
      do_reply = 1'b0;
      if (!cb && ad == 5'h00 && slave_addr_i == 5'h00)
      begin
         reply    = `FBS_ACK_REPLY;
         do_reply = 1'b1;
      end
      else if (cb && ad == 5'h00 && !inf[4])
         do_reply = 1'b1;
      else if (cb && (ad == `FBS_BCAST_ADDR && inf == `FBS_BCAST_INFO))
         do_reply = 1'b0;
      else if (cb && ad == 5'h00 && inf == `FBS_ENTER_PROGRAM_MODE_REQUEST_INFO)
         do_reply = 1'b0;
      else if (addr_hit && ad != 5'h00)
      begin
         do_reply = 1'b1;
         if (!cb)
            reply = inf[4] ? param_i : (inhibit_o ? `FBS_ZERO_REPLY
                                                    : data_in_eff);
         else if (inf[4] && inf[2:0] == 3'h4)
            reply = `FBS_ACK_REPLY;
         else if (inf[4] && inf[2:0] == 3'h6)
            reply = {2'b00, status_bit_one_o, 1'b0};
         else if (inf[4] && inf[2:0] == 3'h0)
            reply = io_config_i;
         else if (inf[4] && inf[2:0] == 3'h1)
            reply = id_code_i;
         else if (inf[4] && inf[2:0] == 3'h2)
            reply = ext_id_o;
         else if (inf[4] && inf[2:0] == 3'h3)
            reply = id_code_two_i;
         else if (!inf[4])
            reply = `FBS_ZERO_REPLY;
         else
            do_reply = 1'b0;
      end
   end

   //--------------------------------------------------------------
   // Main state machine
   //--------------------------------------------------------------
   // Illegal codes jump to a slave reset rather than hang
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state    <= FBS_IDLE;
         req      <= '0;
         soft_rst <= 1'b0;
      end
      else
      begin
         soft_rst <= 1'b0;
         case (state)
            FBS_IDLE:
               if (overtemp_i)
                  state <= FBS_SHUT;
               else if (receive_valid_strobe_i)
               begin
                  req   <= req_body_i;
                  state <= FBS_EXEC;
               end
            FBS_EXEC:
               state <= FBS_REPLY;
            FBS_REPLY:
               state <= FBS_IDLE;
            FBS_SHUT:
               state <= FBS_SHUT; // Only power-on reset leaves
            default:
            begin
               state    <= FBS_IDLE;
               soft_rst <= 1'b1;
            end
         endcase
         if (state == FBS_EXEC && (is_res || wd_hit || strb_hit))
            soft_rst <= 1'b1;
         else if (state != FBS_EXEC && (wd_hit || strb_hit))
            soft_rst <= 1'b1;
      end
   end

   // Send strobe two cycles after the request, far inside 6us
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         transmit_request_strobe_o <= 1'b0;
         reply_info_o              <= `FBS_ZERO_REPLY;
         reply_parity_bit_o        <= 1'b0;
      end
      else
      begin
         transmit_request_strobe_o <= (state == FBS_EXEC) && do_reply;
         if (state == FBS_EXEC && do_reply)
         begin
            reply_info_o       <= reply;
            reply_parity_bit_o <= ^reply; // Even parity
         end
      end
   end

   //--------------------------------------------------------------
   // Flags and ports
   //--------------------------------------------------------------
   // Inhibit, watchdog, ext id, program mode
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         inhibit_o    <= 1'b1;
         wdog_armed_o <= 1'b0;
         ext_id_o     <= 4'h0;
         prog_mode_o  <= 1'b0;
      end
      else if (soft_rst)
      begin
         inhibit_o    <= 1'b1;
         wdog_armed_o <= 1'b0;
      end
      else if (state == FBS_EXEC)
      begin
         if (is_write_parameter_request)
            inhibit_o <= 1'b0;
         if (is_delete_address_request)
            wdog_armed_o <= 1'b0;
         else if (is_write_parameter_request && nv_wdog_en_i && slave_addr_i != 5'h00)
            wdog_armed_o <= 1'b1;
         if (cb && ad == 5'h00 && !inf[4])
            ext_id_o <= inf[3:0];
         if (cb && ad == 5'h00 && inf == `FBS_ENTER_PROGRAM_MODE_REQUEST_INFO && !nv_prog_dis_i)
            prog_mode_o <= 1'b1;
      end
   end

   // Data and parameter outputs; inactive after reset
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         data_out_o                <= `FBS_DATA_RST;
         param_o                   <= `FBS_PARAM_RST;
         data_strobe_o             <= 1'b1;
         data_strobe_oe_o          <= 1'b0;
         parameter_strobe_output_o <= 1'b0;
      end
      else if (soft_rst || state == FBS_SHUT)
      begin
         data_out_o                <= `FBS_DATA_RST;
         param_o                   <= `FBS_PARAM_RST;
         data_strobe_o             <= 1'b1;
         data_strobe_oe_o          <= 1'b0;
         parameter_strobe_output_o <= 1'b0;
      end
      else
      begin
         data_strobe_o             <= !(state == FBS_EXEC && is_data_exchange_request
                                        && !inhibit_o);
         // Enable in step with the low strobe, so the pin really drops
         data_strobe_oe_o          <= state == FBS_EXEC && is_data_exchange_request
                                      && !inhibit_o;
         parameter_strobe_output_o <= state == FBS_EXEC && is_write_parameter_request;
         if (state == FBS_EXEC && is_data_exchange_request && !inhibit_o)
            data_out_o <= inf[3:0];
         if (state == FBS_EXEC && is_write_parameter_request)
            param_o <= inf[3:0]; // Open drain: low bits pull
      end
   end

   // Outputs float for a window after strobe when multiplexed
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         mux_run          <= 1'b0;
         data_out_oe_o    <= 1'b0;
      end
      else
      begin
         if (nv_mux_i && !data_strobe_o && state != FBS_EXEC)
            mux_run <= 1'b1;
         else if (mux_hit || !nv_mux_i)
            mux_run <= 1'b0;
         data_out_oe_o <= (state != FBS_SHUT) && !soft_rst
                          && !(nv_mux_i && mux_run);
      end
   end

   // Watchdog, strobe-pin reset, mux float window, LED blink timers
   fbs_timer #(.W(32)) u_wd
   (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .run_i      (wdog_armed_o && nv_wdog_en_i),
      .clr_i      (state == FBS_EXEC && (is_write_parameter_request || is_data_exchange_request)),
      .limit_i    (32'(WDOG_CYC)),
      .hit_o      (wd_hit)
   );
   assign strb_low = data_strobe_o && !data_strobe_i;
   fbs_timer #(.W(16)) u_strb
   (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .run_i      (strb_low),
      .clr_i      (1'b0),
      .limit_i    (16'(`FBS_STRB_RST_CYC)),
      .hit_o      (strb_hit)
   );
   fbs_timer #(.W(16)) u_mux
   (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .run_i      (mux_run),
      .clr_i      (1'b0),
      .limit_i    (16'(`FBS_MUX_CYC)),
      .hit_o      (mux_hit)
   );
   fbs_timer #(.W(32)) u_led
   (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .run_i      (fault_s),
      .clr_i      (1'b0),
      .limit_i    (32'(LED_CYC)),
      .hit_o      (led_hit)
   );
   fbs_sync u_fault
   (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .d_i        (fault_input_i),
      .q_o        (fault_s)
   );

   // LED priority: optical reply, fault blink, inhibit steady
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         blink            <= 1'b0;
         led_on_o         <= 1'b1;
         status_bit_one_o <= 1'b0;
         shutdown_o       <= 1'b0;
      end
      else
      begin
         status_bit_one_o <= fault_s;
         shutdown_o       <= shutdown_o || state == FBS_SHUT;
         if (!fault_s)
            blink <= 1'b0;
         else if (led_hit)
            blink <= !blink;
         if (optical_lock_i)
            led_on_o <= !optical_reply_i;
         else if (fault_s)
            led_on_o <= !blink;
         else
            led_on_o <= inhibit_o;
      end
   end

   //--------------------------------------------------------------
   // Checks
   //--------------------------------------------------------------
   a_send_bound: assert property (
      receive_valid_strobe_i && state == FBS_IDLE && !overtemp_i
      |-> ##2 (transmit_request_strobe_o == $past(do_reply)))
      else $error("send strobe late");
   a_shut_stay: assert property (
      state == FBS_SHUT |=> state == FBS_SHUT [*3])
      else $error("shutdown left");
   a_inh_led: assert property (
      !optical_lock_i && !fault_s && inhibit_o |=> led_on_o)
      else $error("led not steady");
   a_opt_led: assert property (
      optical_lock_i |=> led_on_o == !$past(optical_reply_i))
      else $error("led not optical");
   a_s1_sync: assert property (
      $rose(fault_input_i) ##1 fault_input_i ##1 fault_input_i
      |=> status_bit_one_o)
      else $error("status bit one lag");
   a_wd_arm: assert property (
      state == FBS_EXEC && is_write_parameter_request && !is_delete_address_request && !soft_rst && nv_wdog_en_i
      && slave_addr_i != 5'h00 |=> wdog_armed_o)
      else $error("watchdog not armed");
   a_wd_off: assert property (
      !nv_wdog_en_i |-> !wd_hit)
      else $error("watchdog fired while off");
   a_inh_clr: assert property (
      soft_rst |=> inhibit_o && !wdog_armed_o)
      else $error("reset flags wrong");
   a_no_data_exchange_request: assert property (
      inhibit_o && $stable(inhibit_o) |=> data_strobe_o)
      else $error("exchange while inhibited");
   c_reply: cover property (@(posedge core_clk_i)
      transmit_request_strobe_o);
   c_blink: cover property (@(posedge core_clk_i) fault_s && led_hit);
   c_wd: cover property (@(posedge core_clk_i) wd_hit);
endmodule

// *** verif/fbs_master_model.sv ***
// -------------------------------------------------------------
// Bus master model: frames requests, waits for a reply
// -------------------------------------------------------------
module fbs_master_model
   import fbs_pkg::*;
(
   input  wire logic        core_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        transmit_request_strobe_i,
   input  wire logic [3:0]  reply_info_i,
   input  wire logic        reply_parity_bit_i,
   output logic             receive_valid_strobe_o,
   output logic [10:0]      req_body_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle lines at time zero
   initial
   begin
      receive_valid_strobe_o = 1'b0;
      req_body_o             = 11'h000;
   end

   // One request, then a short look for the answer
   task automatic send(input logic cb, input logic [4:0] adr,
                       input logic [4:0] inf, output logic got,
                       output fbs_nib_t info, output logic par);
      logic [10:0] b;
      b    = {cb, adr, inf};
      got  = 1'b0;
      info = 4'h0;
      par  = 1'b0;
      @(posedge core_clk_i);
      receive_valid_strobe_o <= 1'b1;
      req_body_o             <= b;
      @(posedge core_clk_i);
      receive_valid_strobe_o <= 1'b0;
      // Released body must not keep showing the old value
      req_body_o             <= ~b;
      // Window far inside the 6 us reply budget
      repeat (4)
      begin
         @(negedge core_clk_i);
         if (transmit_request_strobe_i === 1'b1)
         begin
            got  = 1'b1;
            info = reply_info_i;
            par  = reply_parity_bit_i;
         end
      end
      // Keeps requests at least three cycles apart
      repeat (3) @(posedge core_clk_i);
   endtask
endmodule

// *** verif/tb_top.sv ***
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin bad_count++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end

module tb_top
   import fbs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed
   {
      logic       cb;
      logic [4:0] adr;
      logic [4:0] inf;
      logic       got;
      fbs_nib_t   info;
   } fbs_row_s;

   // -------------------------------------------------------------
   // Signals
   // -------------------------------------------------------------
   logic        core_clk_i, rst_n_i, receive_valid_strobe_i;
   logic        transmit_request_strobe_o, reply_parity_bit_o;
   logic        ext_addr_mode_i, own_select_i, nv_mux_i, nv_invert_i;
   logic        nv_wdog_en_i, nv_prog_dis_i, data_out_oe_o;
   logic        data_strobe_o, data_strobe_oe_o, data_strobe_i;
   logic        parameter_strobe_output_o, fault_input_i;
   logic        status_bit_one_o, optical_lock_i, optical_reply_i;
   logic        led_on_o, overtemp_i, shutdown_o, prog_mode_o;
   logic        wdog_armed_o, inhibit_o, ext_dsr, got, l0, rpar;
   logic [10:0] req_body_i;
   logic [4:0]  slave_addr_i;
   logic [3:0]  reply_info_o, io_config_i, id_code_i, id_code_two_i;
   logic [3:0]  data_in_i, data_out_o, param_i, param_o, ext_id_o;
   logic [3:0]  ext_par, rinfo;
   int          bad_count, n_checks, pst_n, dsr_n, tog;
   logic [4:0]  sel_inf [4] = '{5'h16, 5'h1E, 5'h18, 5'h10};
   logic        sel_got [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
   // Ordinary requests with slave address 5 and inhibit lifted
   fbs_row_s    rows [10] = '{
      '{1'b1, 5'h05, 5'h1E, 1'b1, 4'h0}, '{1'b1, 5'h05, 5'h10, 1'b1, 4'hA},
      '{1'b1, 5'h05, 5'h11, 1'b1, 4'h3}, '{1'b1, 5'h05, 5'h13, 1'b1, 4'hC},
      '{1'b1, 5'h00, 5'h09, 1'b1, 4'h0}, '{1'b1, 5'h05, 5'h12, 1'b1, 4'h9},
      '{1'b1, 5'h06, 5'h1E, 1'b0, 4'h0}, '{1'b0, 5'h00, 5'h06, 1'b0, 4'h0},
      '{1'b0, 5'h05, 5'h05, 1'b1, 4'h6}, '{1'b1, 5'h1F, 5'h15, 1'b0, 4'h0}};

   // Pins: parameter port wired-AND, strobe pin pulled by either side
   assign param_i = param_o & ext_par;
   assign data_strobe_i = ext_dsr && !data_strobe_oe_o;

   fbs_ctrl #(.WDOG_CYC(200), .LED_CYC(50)) dut
   (
      .core_clk_i, .rst_n_i, .receive_valid_strobe_i, .req_body_i,
      .transmit_request_strobe_o, .reply_info_o, .reply_parity_bit_o,
      .slave_addr_i, .ext_addr_mode_i, .own_select_i, .io_config_i,
      .id_code_i, .id_code_two_i, .nv_mux_i, .nv_invert_i, .nv_wdog_en_i,
      .nv_prog_dis_i, .data_in_i, .data_out_o, .data_out_oe_o,
      .data_strobe_o, .data_strobe_oe_o, .data_strobe_i, .param_i, .param_o,
      .parameter_strobe_output_o, .fault_input_i, .status_bit_one_o,
      .optical_lock_i, .optical_reply_i, .led_on_o, .overtemp_i, .shutdown_o,
      .prog_mode_o, .wdog_armed_o, .inhibit_o, .ext_id_o
   );

   fbs_master_model master
   (
      .core_clk_i                (core_clk_i),
      .rst_n_i                   (rst_n_i),
      .transmit_request_strobe_i (transmit_request_strobe_o),
      .reply_info_i              (reply_info_o),
      .reply_parity_bit_i        (reply_parity_bit_o),
      .receive_valid_strobe_o    (receive_valid_strobe_i),
      .req_body_o                (req_body_i)
   );

   // -------------------------------------------------------------
   // Clock, pulse counter, tasks
   // -------------------------------------------------------------
   initial
   begin
      core_clk_i = 1'b0;
      forever #2.5 core_clk_i = ~core_clk_i;
   end

   // Counts parameter strobe pulses and driven-low data strobes
   always @(posedge core_clk_i)
   begin
      if (parameter_strobe_output_o === 1'b1)
         pst_n++;
      if (data_strobe_o === 1'b0 && data_strobe_oe_o === 1'b1)
         dsr_n++;
   end

   task automatic tx(input logic cb, input logic [4:0] adr,
                     input logic [4:0] inf, input logic eg);
      master.send(cb, adr, inf, got, rinfo, rpar);
      `CHK(got, eg)
      if (got === 1'b1)
         `CHK(rpar, ^rinfo)
   endtask

   task automatic do_reset();
      rst_n_i <= 1'b0;
      repeat (6) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      repeat (2) @(posedge core_clk_i);
   endtask

   task automatic tdone(input string s);
      $display("test %s done", s);
   endtask

   task automatic wait_clk(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Hang guard, far beyond the ~10k cycles the tests need
   initial
   begin
      #300us;
      bad_count++;
      $display("watchdog span ran out");
      conclude();
   end

   // -------------------------------------------------------------
   // Tests
   // -------------------------------------------------------------
   initial
   begin
      {rst_n_i, ext_addr_mode_i, nv_mux_i, nv_invert_i} = 4'h0;
      {nv_wdog_en_i, nv_prog_dis_i, fault_input_i} = 3'h0;
      {optical_lock_i, optical_reply_i, overtemp_i} = 3'h0;
      {own_select_i, ext_dsr} = 2'h3;
      slave_addr_i = 5'h05;
      {io_config_i, id_code_i, id_code_two_i} = 12'hA3C;
      data_in_i = 4'h6;
      ext_par = 4'hF;
      do_reset();
      `CHK(inhibit_o, 1'b1)
      `CHK(led_on_o, 1'b1)
      `CHK(param_o, 4'hF)
      `CHK(wdog_armed_o, 1'b0)
      tx(1'b0, 5'h05, 5'h05, 1'b1);
      `CHK(data_out_o, 4'h0)
      tog = pst_n;
      tx(1'b0, 5'h05, 5'h1A, 1'b1);
      `CHK(inhibit_o, 1'b0)
      `CHK(param_o, 4'hA)
      `CHK(pst_n, tog + 1)
      `CHK(wdog_armed_o, 1'b0)
      `CHK(led_on_o, 1'b0)
      tdone("reset and inhibit");
      foreach (rows[k])
      begin
         tx(rows[k].cb, rows[k].adr, rows[k].inf, rows[k].got);
         if (rows[k].got)
            `CHK(rinfo, rows[k].info)
      end
      `CHK(ext_id_o, 4'h9)
      `CHK(inhibit_o, 1'b0)
      tdone("request table");
      tx(1'b0, 5'h05, 5'h1A, 1'b1);
      nv_invert_i <= 1'b1;
      tx(1'b0, 5'h05, 5'h03, 1'b1);
      `CHK(rinfo, 4'h9)
      `CHK(data_out_o, 4'h3)
      `CHK(data_out_oe_o, 1'b1)
      nv_invert_i <= 1'b0;
      // Multiplexed port: outputs float for the window after the strobe
      nv_mux_i <= 1'b1;
      tog = dsr_n;
      tx(1'b0, 5'h05, 5'h07, 1'b1);
      `CHK(dsr_n, tog + 1)
      `CHK(data_out_oe_o, 1'b0)
      wait_clk(600);
      `CHK(data_out_oe_o, 1'b1)
      nv_mux_i <= 1'b0;
      tdone("invert");
      tx(1'b1, 5'h05, 5'h1C, 1'b1);
      `CHK(rinfo, 4'h6)
      fault_input_i <= 1'b1;
      wait_clk(6);
      `CHK(status_bit_one_o, 1'b1)
      tx(1'b1, 5'h05, 5'h1E, 1'b1);
      `CHK(rinfo, 4'h2)
      tog = 0;
      l0 = led_on_o;
      // Flashing while still inhibited: half period is LED_CYC
      repeat (240)
      begin
         @(posedge core_clk_i);
         if (led_on_o !== l0)
            tog++;
         l0 = led_on_o;
      end
      `CHK(tog >= 4 && tog <= 5, 1'b1)
      fault_input_i <= 1'b0;
      wait_clk(6);
      `CHK(status_bit_one_o, 1'b0)
      `CHK(led_on_o, 1'b1)
      optical_lock_i <= 1'b1;
      wait_clk(4);
      l0 = led_on_o;
      optical_reply_i <= 1'b1;
      wait_clk(4);
      `CHK(led_on_o, ~l0)
      {optical_lock_i, optical_reply_i} <= 2'h0;
      tdone("fault and led");
      nv_wdog_en_i <= 1'b1;
      tx(1'b0, 5'h05, 5'h1A, 1'b1);
      `CHK(wdog_armed_o, 1'b1)
      wait_clk(150);
      tx(1'b0, 5'h05, 5'h05, 1'b1);
      wait_clk(150);
      `CHK(wdog_armed_o, 1'b1)
      `CHK(data_out_o, 4'h5)
      wait_clk(80);
      `CHK(wdog_armed_o, 1'b0)
      `CHK(inhibit_o, 1'b1)
      `CHK(data_out_o, 4'h0)
      `CHK(param_o, 4'hF)
      tx(1'b0, 5'h05, 5'h1A, 1'b1);
      tx(1'b1, 5'h05, 5'h00, 1'b1);
      `CHK(wdog_armed_o, 1'b0)
      nv_wdog_en_i <= 1'b0;
      tdone("watchdog");
      tx(1'b0, 5'h05, 5'h1A, 1'b1);
      ext_dsr <= 1'b0;
      wait_clk(7000);
      `CHK(inhibit_o, 1'b0)
      wait_clk(1900);
      ext_dsr <= 1'b1;
      wait_clk(4);
      `CHK(inhibit_o, 1'b1)
      tdone("strobe pin reset");
      ext_addr_mode_i <= 1'b1;
      foreach (sel_inf[k])
         tx(1'b1, 5'h05, sel_inf[k], sel_got[k]);
      ext_addr_mode_i <= 1'b0;
      tdone("select bit");
      nv_prog_dis_i <= 1'b1;
      tx(1'b1, 5'h00, 5'h1D, 1'b0);
      `CHK(prog_mode_o, 1'b0)
      nv_prog_dis_i <= 1'b0;
      tx(1'b1, 5'h00, 5'h1D, 1'b0);
      `CHK(prog_mode_o, 1'b1)
      tdone("program mode");
      do_reset();
      overtemp_i <= 1'b1;
      wait_clk(5);
      `CHK(shutdown_o, 1'b1)
      overtemp_i <= 1'b0;
      tx(1'b1, 5'h05, 5'h1E, 1'b0);
      `CHK(shutdown_o, 1'b1)
      do_reset();
      `CHK(shutdown_o, 1'b0)
      tdone("overtemperature");
      conclude();
   end
endmodule
